//--- core/isr_pkg.sv
// shared constants and types for the inductive sensor result registers
`default_nettype none
package isr_pkg;
  // register addresses
  localparam logic [7:0] ADDR_THR_HIGH_LO   = 8'h06;
  localparam logic [7:0] ADDR_THR_HIGH_HI   = 8'h07;
  localparam logic [7:0] ADDR_THR_LOW_LO    = 8'h08;
  localparam logic [7:0] ADDR_THR_LOW_HI    = 8'h09;
  localparam logic [7:0] ADDR_IRQ_CONFIG    = 8'h0A;
  localparam logic [7:0] ADDR_POWER_CONFIG  = 8'h0B;
  localparam logic [7:0] ADDR_STATUS        = 8'h20;
  localparam logic [7:0] ADDR_PROX_LOW      = 8'h21;
  localparam logic [7:0] ADDR_PROX_HIGH     = 8'h22;
  localparam logic [7:0] ADDR_FREQ_LOW      = 8'h23;
  localparam logic [7:0] ADDR_FREQ_MID      = 8'h24;
  localparam logic [7:0] ADDR_FREQ_HIGH     = 8'h25;

  // reset values
  localparam logic [7:0] RESET_THR_HIGH     = 8'hFF;
  localparam logic [7:0] RESET_THR_LOW      = 8'h00;
  localparam logic [7:0] RESET_IRQ_CONFIG   = 8'h00;
  localparam logic [7:0] RESET_POWER_CONFIG = 8'h00;
  localparam logic [7:0] READ_UNMAPPED      = 8'h00;

  // field positions
  localparam int POWER_MODE_BIT   = 0;
  localparam int STATUS_OSC_BIT   = 7;
  localparam int STATUS_DRDY_BIT  = 6;
  localparam int STATUS_WAKE_BIT  = 5;
  localparam int STATUS_CMP_BIT   = 4;
  localparam int IRQ_FUNC_MSB     = 2;

  // irq pin function codes
  localparam logic [2:0] IRQ_FUNC_NONE    = 3'h0;
  localparam logic [2:0] IRQ_FUNC_WAKEUP  = 3'h1;
  localparam logic [2:0] IRQ_FUNC_COMPARE = 3'h2;
  localparam logic [2:0] IRQ_FUNC_DRDY    = 3'h4;

  // one finished conversion from the measurement core
  typedef struct packed {
    logic [15:0] proximity;
    logic [23:0] frequency_count;
  } isr_conv_t;

  // one register access from the serial decoder
  typedef struct packed {
    logic       write;
    logic       read_start;
    logic [7:0] addr;
    logic [7:0] wdata;
  } isr_req_t;
endpackage
`default_nettype wire

//--- core/isr_byte_reg.sv
// one writable configuration byte with a reset value
`timescale 1ns/1ns
`default_nettype none
module isr_byte_reg #(
  parameter logic [7:0] RESET_VALUE = 8'h00,
  parameter logic [7:0] WRITE_MASK  = 8'hFF
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // write port
  input  wire logic       write_en,
  input  wire logic [7:0] wdata,
  // stored value
  output var  logic [7:0] q
);
  logic [7:0] next_q;

  // masked bits stay zero so reserved fields read back as zero
  always_comb begin
    next_q = q;
    if (write_en) begin
      next_q = wdata & WRITE_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      q <= RESET_VALUE;
    end else begin
      q <= next_q;
    end
  end
endmodule // isr_byte_reg
`default_nettype wire

//--- core/isr_result_regs.sv
// power, status and result registers of the inductive sensor converter
//
// Contract
// - power mode bit 0 low: standby, no conversions taken.
// - power mode bit high: active, conversions enabled.
// - power register at 0x0B, read/write, resets 0x00, upper bits reserved zero.
// - status bit 7 high while oscillation timeout detected.
// - status bit 6 low when new result ready, high otherwise.
// - status bit 5 low on wake-up above high threshold, high when disabled.
// - status bit 4 high below low threshold, low above high threshold.
// - status at 0x20 is read-only, bits 3:0 carry nothing.
// - proximity registers load latest result only when 0x21 read starts.
// - without a 0x21 read, proximity registers keep old contents.
// - proximity result read-only, low byte 0x21, high byte 0x22.
// - frequency count read-only at 0x23, 0x24, 0x25, low to high.
// - high threshold 16 bits at 0x06/0x07, both reset 0xFF.
// - low threshold 16 bits at 0x08/0x09, both reset 0x00.
// - irq pin function: 000 none, 001 wake-up, 010 comparator, 100 ready.
`timescale 1ns/1ns
`default_nettype none
module isr_result_regs (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               reset_n,
  // register access from serial decoder
  input  wire isr_pkg::isr_req_t  req,
  output var  logic [7:0]         reg_rdata,
  output var  logic               reg_rvalid,
  // measurement core
  input  wire logic               conv_done,
  input  wire isr_pkg::isr_conv_t conv_data,
  input  wire logic               oscillation_timeout,
  output var  logic               conv_enable,
  // interrupt pin, active low
  output var  logic               irq_pin_n
);
  logic [7:0]         power_config;
  logic [7:0]         irq_config;
  logic [7:0]         thr_high_lo;
  logic [7:0]         thr_high_hi;
  logic [7:0]         thr_low_lo;
  logic [7:0]         thr_low_hi;
  logic [15:0]        thr_high;
  logic [15:0]        thr_low;
  logic [2:0]         irq_pin_function;
  logic               power_mode_select;
  logic               conv_taken;

  isr_pkg::isr_conv_t latest;
  isr_pkg::isr_conv_t next_latest;
  logic [15:0]        proximity;
  logic [15:0]        next_proximity;
  logic               oscillation_timeout_flag;
  logic               next_oscillation_timeout_flag;
  logic               data_ready_n;
  logic               next_data_ready_n;
  logic               wake_n;
  logic               next_wake_n;
  logic               compare_low;
  logic               next_compare_low;
  logic [7:0]         status;
  logic [7:0]         next_reg_rdata;
  logic               next_reg_rvalid;
  logic               next_conv_enable;
  logic               next_irq_pin_n;

  // configuration bytes
  isr_byte_reg #(.RESET_VALUE(isr_pkg::RESET_THR_HIGH)) u_thr_high_lo (
    .clk      (clk),
    .reset_n  (reset_n),
    .write_en (req.write && req.addr == isr_pkg::ADDR_THR_HIGH_LO),
    .wdata    (req.wdata),
    .q        (thr_high_lo)
  );
  isr_byte_reg #(.RESET_VALUE(isr_pkg::RESET_THR_HIGH)) u_thr_high_hi (
    .clk      (clk),
    .reset_n  (reset_n),
    .write_en (req.write && req.addr == isr_pkg::ADDR_THR_HIGH_HI),
    .wdata    (req.wdata),
    .q        (thr_high_hi)
  );
  isr_byte_reg #(.RESET_VALUE(isr_pkg::RESET_THR_LOW)) u_thr_low_lo (
    .clk      (clk),
    .reset_n  (reset_n),
    .write_en (req.write && req.addr == isr_pkg::ADDR_THR_LOW_LO),
    .wdata    (req.wdata),
    .q        (thr_low_lo)
  );
  isr_byte_reg #(.RESET_VALUE(isr_pkg::RESET_THR_LOW)) u_thr_low_hi (
    .clk      (clk),
    .reset_n  (reset_n),
    .write_en (req.write && req.addr == isr_pkg::ADDR_THR_LOW_HI),
    .wdata    (req.wdata),
    .q        (thr_low_hi)
  );
  isr_byte_reg #(.RESET_VALUE(isr_pkg::RESET_IRQ_CONFIG), .WRITE_MASK(8'h07)) u_irq_config (
    .clk      (clk),
    .reset_n  (reset_n),
    .write_en (req.write && req.addr == isr_pkg::ADDR_IRQ_CONFIG),
    .wdata    (req.wdata),
    .q        (irq_config)
  );
  // reserved upper bits are masked off so they always read zero
  isr_byte_reg #(.RESET_VALUE(isr_pkg::RESET_POWER_CONFIG), .WRITE_MASK(8'h01)) u_power_config (
    .clk      (clk),
    .reset_n  (reset_n),
    .write_en (req.write && req.addr == isr_pkg::ADDR_POWER_CONFIG),
    .wdata    (req.wdata),
    .q        (power_config)
  );

  assign thr_high          = {thr_high_hi, thr_high_lo};
  assign thr_low           = {thr_low_hi, thr_low_lo};
  assign irq_pin_function  = irq_config[isr_pkg::IRQ_FUNC_MSB:0];
  assign power_mode_select = power_config[isr_pkg::POWER_MODE_BIT];
  // standby drops any result the core still delivers
  assign conv_taken        = conv_done && power_mode_select;

  // status and result state
  always_comb begin
    next_latest                   = latest;
    next_proximity                = proximity;
    next_oscillation_timeout_flag = oscillation_timeout;
    next_data_ready_n             = data_ready_n;
    next_wake_n                   = wake_n;
    next_compare_low              = compare_low;
    if (conv_taken) begin
      next_latest = conv_data;
    end
    // reading 0x21 hands the latest result over; writes never do
    if (req.read_start && req.addr == isr_pkg::ADDR_PROX_LOW) begin
      next_proximity    = latest.proximity;
      next_data_ready_n = 1'b1;
    end
    // a fresh result in the same cycle as the hand-over stays pending
    if (conv_taken) begin
      next_data_ready_n = 1'b0;
    end
    // clear on status read, but a new trigger in that cycle wins
    if (req.read_start && req.addr == isr_pkg::ADDR_STATUS) begin
      next_wake_n = 1'b1;
    end
    if (irq_pin_function != isr_pkg::IRQ_FUNC_WAKEUP) begin
      next_wake_n = 1'b1;
    end else if (conv_taken && conv_data.proximity > thr_high) begin
      next_wake_n = 1'b0;
    end
    // hysteresis: between the thresholds the last state holds
    if (conv_taken) begin
      if (conv_data.proximity < thr_low) begin
        next_compare_low = 1'b1;
      end else if (conv_data.proximity > thr_high) begin
        next_compare_low = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      latest                   <= '0;
      proximity                <= '0;
      oscillation_timeout_flag <= 1'b0;
      data_ready_n             <= 1'b1;
      wake_n                   <= 1'b1;
      compare_low              <= 1'b1;
    end else begin
      latest                   <= next_latest;
      proximity                <= next_proximity;
      oscillation_timeout_flag <= next_oscillation_timeout_flag;
      data_ready_n             <= next_data_ready_n;
      wake_n                   <= next_wake_n;
      compare_low              <= next_compare_low;
    end
  end

  // low nibble reads as zero
  always_comb begin
    status                             = 8'h00;
    status[isr_pkg::STATUS_OSC_BIT]    = oscillation_timeout_flag;
    status[isr_pkg::STATUS_DRDY_BIT]   = data_ready_n;
    status[isr_pkg::STATUS_WAKE_BIT]   = wake_n;
    status[isr_pkg::STATUS_CMP_BIT]    = compare_low;
  end

  // read data, irq pin and core enable
  always_comb begin
    next_reg_rvalid = req.read_start;
    next_reg_rdata  = reg_rdata;
    if (req.read_start) begin
      unique case (req.addr)
        isr_pkg::ADDR_THR_HIGH_LO:  next_reg_rdata = thr_high_lo;
        isr_pkg::ADDR_THR_HIGH_HI:  next_reg_rdata = thr_high_hi;
        isr_pkg::ADDR_THR_LOW_LO:   next_reg_rdata = thr_low_lo;
        isr_pkg::ADDR_THR_LOW_HI:   next_reg_rdata = thr_low_hi;
        isr_pkg::ADDR_IRQ_CONFIG:   next_reg_rdata = irq_config;
        isr_pkg::ADDR_POWER_CONFIG: next_reg_rdata = power_config;
        isr_pkg::ADDR_STATUS:       next_reg_rdata = status;
        // low byte comes straight from the result being handed over
        isr_pkg::ADDR_PROX_LOW:     next_reg_rdata = latest.proximity[7:0];
        isr_pkg::ADDR_PROX_HIGH:    next_reg_rdata = proximity[15:8];
        isr_pkg::ADDR_FREQ_LOW:     next_reg_rdata = latest.frequency_count[7:0];
        isr_pkg::ADDR_FREQ_MID:     next_reg_rdata = latest.frequency_count[15:8];
        isr_pkg::ADDR_FREQ_HIGH:    next_reg_rdata = latest.frequency_count[23:16];
        default:                    next_reg_rdata = isr_pkg::READ_UNMAPPED;
      endcase
    end
    next_conv_enable = power_mode_select;
    unique case (irq_pin_function)
      isr_pkg::IRQ_FUNC_WAKEUP:  next_irq_pin_n = wake_n;
      isr_pkg::IRQ_FUNC_COMPARE: next_irq_pin_n = compare_low;
      isr_pkg::IRQ_FUNC_DRDY:    next_irq_pin_n = data_ready_n;
      default:                   next_irq_pin_n = 1'b1;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reg_rdata   <= 8'h00;
      reg_rvalid  <= 1'b0;
      conv_enable <= 1'b0;
      irq_pin_n   <= 1'b1;
    end else begin
      reg_rdata   <= next_reg_rdata;
      reg_rvalid  <= next_reg_rvalid;
      conv_enable <= next_conv_enable;
      irq_pin_n   <= next_irq_pin_n;
    end
  end
endmodule // isr_result_regs
`default_nettype wire

//--- tb/isr_core_model.sv
// stand-in for the measurement core that hands finished conversions over
`timescale 1ns/1ns
`default_nettype none
module isr_core_model (
  // clock and request from the bench
  input  wire logic               clk,
  input  wire logic               fire,
  input  wire isr_pkg::isr_conv_t value,
  // conversion output
  output var  logic               conv_done,
  output var  isr_pkg::isr_conv_t conv_data
);
  initial conv_done = 1'b0;
  initial conv_data = '0;
  // data only means something with the pulse, so it churns otherwise
  always @(negedge clk) begin
    conv_done <= fire;
    conv_data <= fire ? value : ~conv_data;
  end
endmodule // isr_core_model
`default_nettype wire

//--- tb/isr_result_regs_asserts.sv
// port checks for the power, status and result registers
`timescale 1ns/1ns
`default_nettype none
module isr_result_regs_asserts (
  // clock and reset
  input wire logic               clk,
  input wire logic               reset_n,
  // register port
  input wire isr_pkg::isr_req_t  req,
  input wire logic [7:0]         reg_rdata,
  input wire logic               reg_rvalid,
  // measurement core and pin
  input wire logic               conv_done,
  input wire isr_pkg::isr_conv_t conv_data,
  input wire logic               oscillation_timeout,
  input wire logic               conv_enable,
  input wire logic               irq_pin_n
);
  logic       pwr, next_pwr, pwr_wr, rd_pwr, rd_sts, rd_frq;
  logic [7:0] frq, next_frq;
  // power bit rebuilt from write strobes, so no internal probe is needed
  always_comb begin
    pwr_wr   = req.write && req.addr == 8'h0B;
    rd_pwr   = req.read_start && req.addr == 8'h0B;
    rd_sts   = req.read_start && req.addr == 8'h20;
    rd_frq   = req.read_start && req.addr == 8'h23;
    next_pwr = !reset_n ? 1'b0 : pwr_wr ? req.wdata[0] : pwr;
    next_frq = !reset_n ? 8'h00 : conv_done && pwr ? conv_data.frequency_count[7:0] : frq;
  end
  always_ff @(posedge clk) begin
    pwr <= next_pwr;
    frq <= next_frq;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_read_answer: assert property (
    reg_rvalid == $past(req.read_start)) else $error("read answer timing");
  chk_rdata_hold: assert property (
    !reg_rvalid |-> $stable(reg_rdata)) else $error("read data moved");
  chk_standby_off: assert property (
    pwr_wr && !req.wdata[0] |-> ##2 !conv_enable) else $error("standby still converting");
  chk_active_on: assert property (
    pwr_wr && req.wdata[0] |-> ##2 conv_enable) else $error("active mode not enabled");
  chk_enable_follows: assert property (
    conv_enable == $past(pwr)) else $error("enable out of step");
  chk_power_bits: assert property (
    reg_rvalid && $past(rd_pwr) |-> reg_rdata == {7'h00, $past(pwr)}) else $error("power readback");
  chk_osc_flag: assert property (
    reg_rvalid && $past(rd_sts) && $past(reset_n, 2) && $past(oscillation_timeout) == $past(oscillation_timeout, 2)
    |-> reg_rdata[7] == $past(oscillation_timeout)) else $error("timeout flag");
  chk_freq_low: assert property (
    reg_rvalid && $past(rd_frq) |-> reg_rdata == $past(frq)) else $error("frequency low byte");
endmodule // isr_result_regs_asserts
`default_nettype wire

//--- tb/inductive_sensor_result_regs_test.sv
// bench for the inductive sensor result registers
`timescale 1ns/1ns
`default_nettype none
module inductive_sensor_result_regs_test;
  logic               clk = 1'b0;
  logic               reset_n = 1'b0;
  logic               fire = 1'b0;
  logic               osc = 1'b0;
  isr_pkg::isr_req_t  req = '0;
  isr_pkg::isr_conv_t cv = '0;
  isr_pkg::isr_conv_t conv_data;
  logic               conv_done, rvalid, conv_enable, irq_pin_n;
  logic [7:0]         rdata;
  logic [15:0]        exp_q[$];
  logic [15:0]        e, p0;
  logic [23:0]        f0;
  logic [31:0]        seed = 32'h0725;
  logic [7:0]         codes[4] = '{8'h00, 8'h01, 8'h02, 8'h04};
  int                 mismatches = 0;
  int                 checks_done = 0;
  always #20 clk = ~clk;
  isr_core_model core (.clk(clk), .fire(fire), .value(cv), .conv_done(conv_done), .conv_data(conv_data));
  isr_result_regs dut (.clk(clk), .reset_n(reset_n), .req(req), .reg_rdata(rdata), .reg_rvalid(rvalid),
    .conv_done(conv_done), .conv_data(conv_data), .oscillation_timeout(osc), .conv_enable(conv_enable),
    .irq_pin_n(irq_pin_n));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    checks_done++;
    if (seen !== want) begin
      mismatches++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, want);
    end
  endtask
  // one access per cycle; reads note the answer, masked for don't-care bits
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] v, input logic [7:0] m = 8'hFF);
    req = '{w, !w, a, v};
    if (!w) exp_q.push_back({m, v});
    @(negedge clk);
  endtask
  task automatic conv(input logic [15:0] p, input logic [23:0] f);
    req = '0;
    fire <= 1'b1;
    cv <= '{p, f};
    @(negedge clk);
    fire <= 1'b0;
    repeat (3) @(negedge clk);
  endtask
  task automatic report_and_stop();
    if (mismatches == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(negedge clk) begin
    if (rvalid === 1'b1) begin
      e = exp_q.pop_front();
      chk(rdata & e[15:8], e[7:0]);
    end
  end
  initial begin
    #200000;
    mismatches++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(negedge clk);
    reset_n = 1'b1;
    acc(0, 8'h0B, 8'h00);
    acc(0, 8'h07, 8'hFF);
    acc(0, 8'h08, 8'h00);
    acc(0, 8'h30, 8'h00);
    conv(16'h9000, 24'h0);
    chk({7'h00, conv_enable}, 8'h00);
    acc(0, 8'h20, 8'h40, 8'h40);
    foreach (codes[i]) begin
      acc(1, 8'h0A, codes[i]);
      acc(0, 8'h0A, codes[i]);
    end
    acc(1, 8'h07, 8'h80);
    acc(1, 8'h09, 8'h10);
    acc(0, 8'h07, 8'h80);
    acc(1, 8'h0B, 8'hFF);
    acc(0, 8'h0B, 8'h01);
    p0 = 16'(xs()) | 16'h8100;
    f0 = 24'(xs());
    conv(p0, f0);
    chk({7'h00, conv_enable}, 8'h01);
    chk({7'h00, irq_pin_n}, 8'h00);
    acc(0, 8'h20, 8'h00, 8'h50);
    acc(0, 8'h21, p0[7:0]);
    acc(0, 8'h22, p0[15:8]);
    acc(0, 8'h23, f0[7:0]);
    acc(0, 8'h24, f0[15:8]);
    acc(0, 8'h25, f0[23:16]);
    acc(0, 8'h20, 8'h40, 8'h40);
    chk({7'h00, irq_pin_n}, 8'h01);
    conv(16'h0800, 24'hA5A5A5);
    acc(1, 8'h21, 8'h3C);
    acc(1, 8'h22, 8'h3C);
    acc(0, 8'h22, p0[15:8]);
    acc(0, 8'h23, 8'hA5);
    acc(0, 8'h20, 8'h10, 8'h50);
    acc(0, 8'h21, 8'h00);
    acc(0, 8'h22, 8'h08);
    acc(1, 8'h0B, 8'h00);
    acc(1, 8'h0A, 8'h01);
    acc(1, 8'h0B, 8'h01);
    osc = 1'b1;
    conv(16'hC000, 24'h0);
    chk({7'h00, irq_pin_n}, 8'h00);
    acc(0, 8'h20, 8'h80, 8'hA0);
    acc(0, 8'h21, 8'h00);
    acc(0, 8'h20, 8'h20, 8'h20);
    acc(1, 8'h0B, 8'h00);
    acc(1, 8'h0A, 8'h02);
    req = '0;
    @(negedge clk);
    // last result sat above the high threshold, so the comparator pin is low
    chk({7'h00, irq_pin_n}, 8'h00);
    repeat (4) @(negedge clk);
    // a read that never answered leaves its note behind
    chk(8'(exp_q.size()), 8'h00);
    report_and_stop();
  end
endmodule // inductive_sensor_result_regs_test
bind isr_result_regs isr_result_regs_asserts u_chk (.clk(clk), .reset_n(reset_n), .req(req), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .conv_done(conv_done), .conv_data(conv_data), .oscillation_timeout(oscillation_timeout),
  .conv_enable(conv_enable), .irq_pin_n(irq_pin_n));
`default_nettype wire
